/* File: src/nds_map.svh */
// Purpose: register offsets, fields, reset values and timing counts
// Assumes: 50 MHz clock
// Notes: definitions only
`ifndef NDS_MAP_SVH
`define NDS_MAP_SVH

// --------------------------------------------------
// register offsets (byte addresses)
// --------------------------------------------------
`define NDS_CTRL_OFS 8'h00
`define NDS_TMO_OFS 8'h04
`define NDS_COMPAT_OFS 8'h08
`define NDS_DEST_HI_OFS 8'h0c
`define NDS_DEST_LO_OFS 8'h10
`define NDS_STAT_OFS 8'h14

// --------------------------------------------------
// field positions
// --------------------------------------------------
`define NDS_CTRL_START 0
`define NDS_CTRL_NODE 1
`define NDS_CTRL_NAMED 2
`define NDS_CTRL_API 3
`define NDS_COMPAT_SUCC 1
`define NDS_STAT_BUSY 0
`define NDS_STAT_REFUSED 1
`define NDS_STAT_ERR 2

// --------------------------------------------------
// values
// --------------------------------------------------
`define NDS_TMO_RESET 16'h0019
`define NDS_COMPAT_RESET 8'h00
`define NDS_LONG_ADDR 16'hfffe
`define NDS_RESP_FRAME 8'h88
`define NDS_RESP_OKAY 2'b00
`define NDS_RESP_SLVERR 2'b10

// --------------------------------------------------
// timing: one timeout unit, in ns
// --------------------------------------------------
`define NDS_TICK_NS 1000000
`define NDS_CLK_NS 20
`define NDS_TICK_CYCLES (`NDS_TICK_NS / `NDS_CLK_NS)

`endif

/* File: src/nds_pkg.sv */
// Purpose: types of the discovery sequencer
// Assumes: nothing
// Notes: offsets live in nds_map.svh
package nds_pkg;

  typedef enum logic [1:0] {
    NDS_IDLE = 2'b00,
    NDS_WAIT = 2'b01
  } nds_state_type;

  typedef struct packed {
    logic [31:0] pre;
    logic [15:0] ticks;
    logic running;
    logic expired;
  } nds_tmr_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [15:0] tmo;
    logic [7:0] compat;
    logic [31:0] dest_hi;
    logic [31:0] dest_lo;
    logic refused;
    logic last_err;
    logic [7:0] reply_cnt;
    nds_state_type state;
    logic node_cmd;
    logic named;
    logic api;
    logic tmr_load;
    logic tmr_stop;
    logic busy;
    logic bcast_req;
    logic bcast_named;
    logic text_reply;
    logic frame_reply;
    logic crlf;
    logic ok_text;
    logic error_text;
    logic resp_frame;
    logic resp_error;
    logic exit_cmd;
  } nds_top_type;

endpackage

/* File: src/nds_tmr_if.sv */
// Purpose: link between sequencer and its timeout counter
// Assumes: one clock
// Notes: load wins over stop
`timescale 1ns/1ps
`default_nettype none
interface nds_tmr_if;
  logic load;
  logic stop;
  logic [15:0] ticks;
  logic expired;
  logic running;
  modport ctl (output load, output stop, output ticks, input expired, input running);
  modport tmr (input load, input stop, input ticks, output expired, output running);
endinterface
`default_nettype wire

/* File: src/nds_timer.sv */
// Purpose: discovery timeout counter in units of TICK_CYCLES
// Assumes: synchronous active-high reset
// Notes: a zero timeout counts as one unit
`timescale 1ns/1ps
`default_nettype none
`include "nds_map.svh"
module nds_timer
#(
  parameter int TICK_CYCLES = `NDS_TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  nds_tmr_if.tmr t
);
  import nds_pkg::*;

  nds_tmr_type r;
  nds_tmr_type next_r;

  always_comb
  begin
    next_r = r;
    next_r.expired = 1'b0;
    if (t.load)
    begin
      next_r.running = 1'b1;
      next_r.ticks = (t.ticks == 16'h0000) ? 16'h0001 : t.ticks;
      next_r.pre = 32'(TICK_CYCLES - 1);
    end
    else if (t.stop)
    begin
      next_r.running = 1'b0;
    end
    else if (r.running)
    begin
      if (r.pre == 32'h0000_0000)
      begin
        next_r.pre = 32'(TICK_CYCLES - 1);
        if (r.ticks == 16'h0001)
        begin
          next_r.running = 1'b0;
          next_r.expired = 1'b1;
        end
        else
        begin
          next_r.ticks = r.ticks - 16'h0001;
        end
      end
      else
      begin
        next_r.pre = r.pre - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign t.expired = r.expired;
  assign t.running = r.running;

  tmr_load_a: assert property (@(posedge clk) disable iff (rst) t.load |=> t.running && !t.expired)
    else $error("timer did not start on load");

endmodule
`default_nettype wire

/* File: src/nds_sequencer.sv */
// Purpose: node discovery command sequencer behind an AXI4-Lite slave
// Assumes: radio side reports replies as one-cycle pulses, name match decided remotely
// Notes:
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "nds_map.svh"
module nds_sequencer
#(
  parameter int TICK_CYCLES = `NDS_TICK_CYCLES
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reply_valid,
  input wire logic reply_name_match,
  input wire logic [15:0] reply_short_addr,
  input wire logic [31:0] reply_serial_high,
  input wire logic [31:0] reply_serial_low,
  output logic bcast_req,
  output logic bcast_named,
  output logic busy,
  output logic host_text_reply,
  output logic host_frame_reply,
  output logic host_crlf,
  output logic host_ok_text,
  output logic host_error_text,
  output logic host_resp_frame,
  output logic host_resp_error,
  output logic exit_cmd_mode,
  output logic [31:0] dest_addr_high,
  output logic [31:0] dest_addr_low
);
  import nds_pkg::*;

  // --------------------------------------------------
  // state and timer link
  // --------------------------------------------------
  nds_top_type r;
  nds_top_type next_r;
  nds_tmr_if tif();

  nds_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .clk(clk),
    .rst(rst),
    .t(tif)
  );

  assign tif.load = r.tmr_load;
  assign tif.stop = r.tmr_stop;
  assign tif.ticks = r.tmo;

  // an old expiry may still be in flight while the new load is pending
  wire logic tmo_hit = (r.state == NDS_WAIT) && tif.expired && !r.tmr_load;
  wire logic rep_hit = (r.state == NDS_WAIT) && !tmo_hit && reply_valid
                       && (!r.named || reply_name_match);
  wire logic do_wr = r.aw_got && r.w_got && !r.bvalid;
  wire logic legacy = r.compat[`NDS_COMPAT_SUCC];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        res[i*8 +: 8] = nw[i*8 +: 8];
    return res;
  endfunction

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb
  begin
    logic [31:0] mw;
    mw = 32'h0000_0000;
    next_r = r;
    next_r.tmr_load = 1'b0;
    next_r.tmr_stop = 1'b0;
    next_r.bcast_req = 1'b0;
    next_r.bcast_named = 1'b0;
    next_r.text_reply = 1'b0;
    next_r.frame_reply = 1'b0;
    next_r.crlf = 1'b0;
    next_r.ok_text = 1'b0;
    next_r.error_text = 1'b0;
    next_r.resp_frame = 1'b0;
    next_r.resp_error = 1'b0;
    next_r.exit_cmd = 1'b0;

    // write channel: address and data in either order
    if (s_axi_awvalid && r.awready)
    begin
      next_r.aw_got = 1'b1;
      next_r.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready)
    begin
      next_r.w_got = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready)
      next_r.bvalid = 1'b0;

    // --------------------------------------------------
    // discovery in progress
    // --------------------------------------------------
    if (tmo_hit)
    begin
      next_r.state = NDS_IDLE;
      next_r.busy = 1'b0;
      if (r.node_cmd)
      begin
        next_r.last_err = 1'b1;
        next_r.error_text = !r.api;
        next_r.resp_frame = r.api;
        next_r.resp_error = r.api;
      end
      else if (r.named && legacy)
      begin
        next_r.ok_text = !r.api;
        next_r.resp_frame = r.api;
      end
      else if (r.named)
      begin
        next_r.last_err = 1'b1;
        next_r.error_text = !r.api;
        next_r.resp_frame = r.api;
        next_r.resp_error = r.api;
      end
      else if (!r.api)
        next_r.crlf = 1'b1;
      else
        next_r.resp_frame = legacy && (r.reply_cnt == 8'h00);
    end
    else if (rep_hit)
    begin
      if (r.node_cmd)
      begin
        // only the destination changes; nothing about the node goes out
        if (reply_short_addr == `NDS_LONG_ADDR)
        begin
          next_r.dest_hi = reply_serial_high;
          next_r.dest_lo = reply_serial_low;
        end
        else
        begin
          next_r.dest_hi = 32'h0000_0000;
          next_r.dest_lo = {16'h0000, reply_short_addr};
        end
        next_r.state = NDS_IDLE;
        next_r.busy = 1'b0;
        next_r.tmr_stop = 1'b1;
        next_r.ok_text = !r.api;
        next_r.exit_cmd = !r.api;
        next_r.resp_frame = r.api;
      end
      else
      begin
        next_r.text_reply = !r.api;
        next_r.frame_reply = r.api;
        next_r.reply_cnt = r.reply_cnt + 8'h01;
        if (r.named && !legacy)
        begin
          next_r.state = NDS_IDLE;
          next_r.busy = 1'b0;
          next_r.tmr_stop = 1'b1;
          next_r.crlf = !r.api;
        end
      end
    end

    // --------------------------------------------------
    // register write
    // --------------------------------------------------
    if (do_wr)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `NDS_RESP_OKAY;
      case (r.waddr)
        `NDS_STAT_OFS:
        begin
          if (r.wstrb[0] && r.wdata[`NDS_STAT_REFUSED])
            next_r.refused = 1'b0;
        end
        `NDS_CTRL_OFS, `NDS_TMO_OFS, `NDS_COMPAT_OFS, `NDS_DEST_HI_OFS, `NDS_DEST_LO_OFS:
        begin
          if (r.state != NDS_IDLE)
          begin
            // commands stay locked out until the discovery returns to NDS_IDLE, on timeout or on a reply that ends it
            next_r.bresp = `NDS_RESP_SLVERR;
          end
          else if (r.waddr == `NDS_TMO_OFS)
          begin
            mw = merge({16'h0000, r.tmo}, r.wdata, r.wstrb);
            next_r.tmo = mw[15:0];
          end
          else if (r.waddr == `NDS_COMPAT_OFS)
          begin
            mw = merge({24'h000000, r.compat}, r.wdata, r.wstrb);
            next_r.compat = mw[7:0];
          end
          else if (r.waddr == `NDS_DEST_HI_OFS)
            next_r.dest_hi = merge(r.dest_hi, r.wdata, r.wstrb);
          else if (r.waddr == `NDS_DEST_LO_OFS)
            next_r.dest_lo = merge(r.dest_lo, r.wdata, r.wstrb);
          else if (r.wstrb[0] && r.wdata[`NDS_CTRL_START])
          begin
            next_r.node_cmd = r.wdata[`NDS_CTRL_NODE];
            next_r.named = r.wdata[`NDS_CTRL_NAMED];
            next_r.api = r.wdata[`NDS_CTRL_API];
            next_r.reply_cnt = 8'h00;
            next_r.last_err = 1'b0;
            if (r.wdata[`NDS_CTRL_NODE] && !r.wdata[`NDS_CTRL_NAMED])
            begin
              next_r.last_err = 1'b1;
              next_r.error_text = !r.wdata[`NDS_CTRL_API];
              next_r.resp_frame = r.wdata[`NDS_CTRL_API];
              next_r.resp_error = r.wdata[`NDS_CTRL_API];
            end
            else
            begin
              next_r.state = NDS_WAIT;
              next_r.busy = 1'b1;
              next_r.tmr_load = 1'b1;
              next_r.bcast_req = 1'b1;
              next_r.bcast_named = r.wdata[`NDS_CTRL_NAMED];
            end
          end
        end
        default:
          next_r.bresp = `NDS_RESP_SLVERR;
      endcase
      if (next_r.bresp == `NDS_RESP_SLVERR && r.waddr != `NDS_STAT_OFS
          && r.state != NDS_IDLE)
        next_r.refused = 1'b1;
    end
    next_r.awready = !next_r.aw_got;
    next_r.wready = !next_r.w_got;

    // --------------------------------------------------
    // register read
    // --------------------------------------------------
    if (r.arready && s_axi_arvalid)
    begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = `NDS_RESP_OKAY;
      case (s_axi_araddr)
        `NDS_CTRL_OFS:
          next_r.rdata = {28'h0000000, r.api, r.named, r.node_cmd, r.busy};
        `NDS_TMO_OFS:
          next_r.rdata = {16'h0000, r.tmo};
        `NDS_COMPAT_OFS:
          next_r.rdata = {24'h000000, r.compat};
        `NDS_DEST_HI_OFS:
          next_r.rdata = r.dest_hi;
        `NDS_DEST_LO_OFS:
          next_r.rdata = r.dest_lo;
        `NDS_STAT_OFS:
          next_r.rdata = {16'h0000, r.reply_cnt, 5'h00, r.last_err, r.refused, r.busy};
        default:
        begin
          next_r.rdata = 32'h0000_0000;
          next_r.rresp = `NDS_RESP_SLVERR;
        end
      endcase
    end
    else if (r.rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r <= '0;
      r.awready <= 1'b1;
      r.wready <= 1'b1;
      r.arready <= 1'b1;
      r.tmo <= `NDS_TMO_RESET;
      r.compat <= `NDS_COMPAT_RESET;
    end
    else
      r <= next_r;
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  assign s_axi_awready = r.awready;
  assign s_axi_wready = r.wready;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.arready;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign bcast_req = r.bcast_req;
  assign bcast_named = r.bcast_named;
  assign busy = r.busy;
  assign host_text_reply = r.text_reply;
  assign host_frame_reply = r.frame_reply;
  assign host_crlf = r.crlf;
  assign host_ok_text = r.ok_text;
  assign host_error_text = r.error_text;
  assign host_resp_frame = r.resp_frame;
  assign host_resp_error = r.resp_error;
  assign exit_cmd_mode = r.exit_cmd;
  assign dest_addr_high = r.dest_hi;
  assign dest_addr_low = r.dest_lo;

  // --------------------------------------------------
  // checks
  // --------------------------------------------------
  busy_refuse_a: assert property (@(posedge clk) disable iff (rst)
    do_wr && r.state == NDS_WAIT && r.waddr == `NDS_CTRL_OFS && !tmo_hit && !rep_hit
    |=> s_axi_bvalid && s_axi_bresp == `NDS_RESP_SLVERR && busy)
    else $error("command taken while discovery busy");
  gen_crlf_a: assert property (@(posedge clk) disable iff (rst)
    tmo_hit && !r.node_cmd && !r.named && !r.api |=> host_crlf && !busy ##1 !host_crlf)
    else $error("no line end after general discovery");
  api_silent_a: assert property (@(posedge clk) disable iff (rst)
    tmo_hit && !r.node_cmd && !r.named && r.api && !legacy
    |=> !host_resp_frame && !host_crlf && !host_frame_reply)
    else $error("output after silent api discovery");
  compat_ok_a: assert property (@(posedge clk) disable iff (rst)
    tmo_hit && !r.node_cmd && !r.named && r.api && legacy && r.reply_cnt == 8'h00
    |=> host_resp_frame && !host_resp_error)
    else $error("missing ok frame in legacy mode");
  direct_end_a: assert property (@(posedge clk) disable iff (rst)
    rep_hit && !r.node_cmd && r.named && !legacy && !r.api
    |=> host_text_reply && host_crlf && !busy)
    else $error("directed discovery did not end on reply");
  legacy_wait_a: assert property (@(posedge clk) disable iff (rst)
    rep_hit && !r.node_cmd && r.named && legacy |=> busy && !host_crlf)
    else $error("legacy directed discovery ended early");
  short_dest_a: assert property (@(posedge clk) disable iff (rst)
    rep_hit && r.node_cmd && reply_short_addr != `NDS_LONG_ADDR
    |=> dest_addr_high == 32'h0000_0000 && dest_addr_low == {16'h0000, $past(reply_short_addr)})
    else $error("short destination not loaded");
  long_dest_a: assert property (@(posedge clk) disable iff (rst)
    rep_hit && r.node_cmd && reply_short_addr == `NDS_LONG_ADDR
    |=> dest_addr_high == $past(reply_serial_high) && dest_addr_low == $past(reply_serial_low))
    else $error("long destination not loaded");
  node_quiet_a: assert property (@(posedge clk) disable iff (rst)
    rep_hit && r.node_cmd |=> !host_text_reply && !host_frame_reply && !busy)
    else $error("discover-node leaked reply");
  node_timeout_a: assert property (@(posedge clk) disable iff (rst)
    tmo_hit && r.node_cmd |=> (host_error_text || host_resp_error) && !busy)
    else $error("discover-node timeout without error");

endmodule
`default_nettype wire

/* File: tb/nds_radio_model.sv */
// Purpose: remote radio node answering discovery broadcasts
// Assumes: one node; a reply is a one-cycle pulse
// Notes: identity lines show the inverse between replies
`timescale 1ns/1ps
`default_nettype none
module nds_radio_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bcast_req,
  input wire logic bcast_named,
  input wire logic answer,
  input wire logic name_ok,
  input wire logic [7:0] delay,
  input wire logic [15:0] short_addr,
  input wire logic [63:0] serial,
  output logic reply_valid,
  output logic reply_name_match,
  output logic [15:0] reply_short_addr,
  output logic [31:0] reply_serial_high,
  output logic [31:0] reply_serial_low
);
  logic armed;
  logic [7:0] cnt;
  // --------------------------------------------------
  // reply timing
  // --------------------------------------------------
  always_ff @(posedge clk)
  begin
    reply_valid <= 1'b0;
    if (rst)
      armed <= 1'b0;
    else if (bcast_req)
    begin
      armed <= answer && (!bcast_named || name_ok);
      cnt <= delay;
    end
    else if (armed)
    begin
      if (cnt == 8'h00)
      begin
        reply_valid <= 1'b1;
        armed <= 1'b0;
      end
      else
        cnt <= cnt - 8'h01;
    end
  end
  // stale identity must not look valid
  assign reply_name_match = reply_valid ? name_ok : ~name_ok;
  assign reply_short_addr = reply_valid ? short_addr : ~short_addr;
  assign reply_serial_high = reply_valid ? serial[63:32] : ~serial[63:32];
  assign reply_serial_low = reply_valid ? serial[31:0] : ~serial[31:0];
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the discovery sequencer
// Assumes: TICK_CYCLES 4, timeout of 5 units
// Notes: short ticks keep every timeout near twenty cycles
`timescale 1ns/1ps
`default_nettype none
`include "nds_map.svh"
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import nds_pkg::*;
  localparam int TICKS = 4;
  localparam int TMO = 5;
  localparam int FULL = 2 + TMO * TICKS;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] awaddr, araddr, delay;
  logic awvalid, wvalid, bready, arvalid, rready, answer, name_ok;
  logic [31:0] wdata;
  logic [15:0] m_short;
  logic [63:0] m_serial;
  wire awready, wready, bvalid, arready, rvalid, rv, rm, breq, bnam, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, dah, dal, rsh, rsl;
  wire [15:0] rsa;
  wire [9:0] outs;
  int n_mismatch = 0, n_tests = 0;
  assign outs[9] = breq;
  assign outs[8] = breq & bnam;
  nds_sequencer #(.TICK_CYCLES(TICKS)) nds_sequencer_i (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reply_valid(rv), .reply_name_match(rm), .reply_short_addr(rsa),
    .reply_serial_high(rsh), .reply_serial_low(rsl), .bcast_req(breq), .bcast_named(bnam),
    .busy(busy), .host_text_reply(outs[7]), .host_frame_reply(outs[6]), .host_crlf(outs[5]),
    .host_ok_text(outs[4]), .host_error_text(outs[3]), .host_resp_frame(outs[2]),
    .host_resp_error(outs[1]), .exit_cmd_mode(outs[0]), .dest_addr_high(dah),
    .dest_addr_low(dal));
  nds_radio_model nds_radio_model_i (.clk(clk), .rst(rst), .bcast_req(breq),
    .bcast_named(bnam), .answer(answer), .name_ok(name_ok), .delay(delay),
    .short_addr(m_short), .serial(m_serial), .reply_valid(rv), .reply_name_match(rm),
    .reply_short_addr(rsa), .reply_serial_high(rsh), .reply_serial_low(rsl));
  always #10 clk = ~clk;
  // --------------------------------------------------
  // tasks
  // --------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d))
    begin
      @(posedge clk);
      aw_d |= awready;
      w_d |= wready;
      awvalid <= !aw_d;
      wvalid <= !w_d;
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    `CHK(bresp, e)
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask
  // mode 0: full timeout, 1: early finish, 2: never busy
  task automatic run(input logic [3:0] ctrl, input logic [7:0] compat, input logic ans,
    input logic ok, input logic [7:0] dly, input logic [9:0] eo, input int mode);
    logic [9:0] seen;
    int nb;
    seen = '0;
    nb = 0;
    answer <= ans;
    name_ok <= ok;
    delay <= dly;
    wr(`NDS_COMPAT_OFS, {24'h0, compat}, `NDS_RESP_OKAY);
    wr(`NDS_CTRL_OFS, {28'h0, ctrl}, `NDS_RESP_OKAY);
    forever
    begin
      seen |= outs;
      if (busy !== 1'b1)
        break;
      nb++;
      @(posedge clk);
    end
    `CHK(seen, eo)
    if (mode == 0) `CHK(nb, FULL)
    else if (mode == 1) `CHK(nb > 0 && nb < FULL, 1'b1)
    else `CHK(nb, 0)
  endtask
  task automatic chk_dest(input logic [31:0] h, input logic [31:0] l);
    `CHK(dah, h)
    `CHK(dal, l)
    rd(`NDS_DEST_HI_OFS, h, `NDS_RESP_OKAY);
    rd(`NDS_DEST_LO_OFS, l, `NDS_RESP_OKAY);
  endtask
  // --------------------------------------------------
  // tests
  // --------------------------------------------------
  initial
  begin
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {answer, name_ok, delay} = '0;
    m_short = 16'h1234;
    m_serial = 64'h0a1b2c3d_4e5f6071;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`NDS_TMO_OFS, {16'h0, `NDS_TMO_RESET}, `NDS_RESP_OKAY);
    rd(`NDS_COMPAT_OFS, 32'h0, `NDS_RESP_OKAY);
    rd(`NDS_STAT_OFS, 32'h0, `NDS_RESP_OKAY);
    rd(8'h18, 32'h0, `NDS_RESP_SLVERR);
    wr(8'h18, 32'h1, `NDS_RESP_SLVERR);
    chk_dest(32'h0, 32'h0);
    wr(`NDS_TMO_OFS, TMO, `NDS_RESP_OKAY);
    wr(`NDS_CTRL_OFS, 32'h1, `NDS_RESP_OKAY);
    wr(`NDS_TMO_OFS, 32'h9, `NDS_RESP_SLVERR);
    wr(`NDS_CTRL_OFS, 32'h9, `NDS_RESP_SLVERR);
    rd(`NDS_STAT_OFS, 32'h3, `NDS_RESP_OKAY);
    while (busy === 1'b1) @(posedge clk);
    wr(`NDS_STAT_OFS, 32'h2, `NDS_RESP_OKAY);
    rd(`NDS_STAT_OFS, 32'h0, `NDS_RESP_OKAY);
    rd(`NDS_TMO_OFS, TMO, `NDS_RESP_OKAY);
    run(4'h1, 8'h00, 1'b1, 1'b1, 8'd3, 10'h2a0, 0);
    run(4'h1, 8'h00, 1'b1, 1'b1, 8'd19, 10'h220, 0);
    run(4'h9, 8'h00, 1'b0, 1'b1, 8'd3, 10'h200, 0);
    run(4'h9, 8'h02, 1'b0, 1'b1, 8'd3, 10'h204, 0);
    run(4'h9, 8'h02, 1'b1, 1'b1, 8'd3, 10'h240, 0);
    rd(`NDS_STAT_OFS, 32'h100, `NDS_RESP_OKAY);
    run(4'h5, 8'h00, 1'b1, 1'b1, 8'd3, 10'h3a0, 1);
    run(4'h5, 8'h00, 1'b1, 1'b0, 8'd3, 10'h308, 0);
    run(4'hd, 8'h00, 1'b1, 1'b1, 8'd3, 10'h340, 1);
    run(4'hd, 8'h00, 1'b1, 1'b0, 8'd3, 10'h306, 0);
    run(4'h5, 8'h02, 1'b1, 1'b0, 8'd3, 10'h310, 0);
    run(4'hd, 8'h02, 1'b1, 1'b1, 8'd3, 10'h344, 0);
    run(4'h7, 8'h00, 1'b1, 1'b1, 8'd3, 10'h311, 1);
    chk_dest(32'h0, 32'h1234);
    m_short <= `NDS_LONG_ADDR;
    run(4'hf, 8'h00, 1'b1, 1'b1, 8'd3, 10'h304, 1);
    chk_dest(m_serial[63:32], m_serial[31:0]);
    run(4'h3, 8'h00, 1'b1, 1'b1, 8'd3, 10'h008, 2);
    run(4'hb, 8'h00, 1'b1, 1'b1, 8'd3, 10'h006, 2);
    run(4'hf, 8'h00, 1'b1, 1'b0, 8'd3, 10'h306, 0);
    chk_dest(m_serial[63:32], m_serial[31:0]);
    rd(`NDS_STAT_OFS, 32'h4, `NDS_RESP_OKAY);
    conclude();
  end
  // a hung handshake ends the run here
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
